// *** hw/ctb_controller.sv ***
// Operation
// R1: respond only at four consecutive register addresses
// R2: register and read/write pick keyboard or printer
// R3: printer data write latches bus character
// R4: software waits for printer ready before writing
// R5: printer ready with enable requests interrupt
// R6: vector 60 keyboard, 64 printer on grant
// R7: keystroke strobe loads 7-bit code into buffer
// R8: loaded keyboard buffer sets done flag
// R9: done with enable requests vectored interrupt
// R10: status reads show ready, done, loopback, enables
// R11: keyboard bit 07 chosen by strap option
// R12: only one eighth-bit strap ever selected
// R13: parallel 7-bit codes plus four control lines
// R14: one character per transfer, interrupt or polling
// R15: software echoes keystrokes to printer itself
// R16: local paper advance leaves controller untouched
// R17: all 128 keyboard codes pass unchanged
// R18: default base octal 777560, even word steps
// R19: loopback zeroes keyboard data, printer write sets done
// R20: printer enable bit 06, read/write, reset clears
// R21: keyboard read clears done, printer write clears ready
// R22: keyboard request wins over printer request
`timescale 1ns/10ps
`default_nettype none
`include "ctb_map.svh"

module ctb_controller
   import ctb_pkg::*;
#(
   parameter logic [17:0] BASE_ADDR = `CTB_BASE_ADDR
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [17:0] bus_addr,
   input  wire logic [15:0] bus_wdata,
   input  wire logic        bus_rd,
   input  wire logic        bus_wr,
   output logic [15:0]      bus_rdata,
   output logic             bus_ack,
   output logic             irq_req,
   input  wire logic        irq_grant,
   output logic [7:0]       irq_vector,
   output logic             irq_vector_valid,
   input  wire logic        msb_follows_loopback_strap,
   input  wire logic        msb_zero_strap,
   ctb_link_if.ctl          link
);

   ctb_char_t   kbuf_r;
   logic        done_r;
   logic        kie_r;
   logic        pie_r;
   logic        loopback_test_bit_r;
   logic        pend_r;
   logic        ready_r;
   ctb_char_t   pbuf_r;
   logic        pstb_r;
   logic [15:0] rdata_r;
   logic        ack_r;
   logic [7:0]  vec_r;
   logic        vec_vld_r;

   // address decode, base aligned to eight bytes
   wire         base_hit = (bus_addr[17:3] == BASE_ADDR[17:3]); // R1 R18
   wire         hit_kbs  = base_hit && (bus_addr[2:0] == `CTB_OFS_KBS);
   wire         hit_kbb  = base_hit && (bus_addr[2:0] == `CTB_OFS_KBB);
   wire         hit_prs  = base_hit && (bus_addr[2:0] == `CTB_OFS_PRS);
   wire         hit_prb  = base_hit && (bus_addr[2:0] == `CTB_OFS_PRB);
   wire         hit_any  = hit_kbs | hit_kbb | hit_prs | hit_prb; // R1

   wire         kbs_wr   = hit_kbs & bus_wr; // R2
   wire         kbb_rd   = hit_kbb & bus_rd; // R2
   wire         prs_wr   = hit_prs & bus_wr; // R2
   wire         prb_wr   = hit_prb & bus_wr; // R2

   // keyboard side; set wins over the read clear
   wire         key_set  = link.key_strobe | (prb_wr & loopback_test_bit_r); // R8 R19
   wire         done_nxt = key_set | (done_r & ~kbb_rd); // R8 R21
   wire         kie_nxt  = kbs_wr ? bus_wdata[`CTB_BIT_IE] : kie_r;
   wire         pie_nxt  = prs_wr ? bus_wdata[`CTB_BIT_IE] : pie_r; // R20
   wire         mnt_nxt  = prs_wr ? bus_wdata[`CTB_BIT_LOOPBACK_TEST_BIT] : loopback_test_bit_r;
   ctb_char_t   kbuf_nxt;
   assign kbuf_nxt = link.key_strobe ? link.key_code : kbuf_r; // R7 R17

   // printer side: busy from write until terminal drops its ready line
   wire         pend_nxt  = prb_wr | (pend_r & link.printer_ready);
   wire         ready_nxt = link.printer_ready & ~pend_nxt; // R21
   ctb_char_t   pbuf_nxt;
   assign pbuf_nxt = prb_wr ? bus_wdata[6:0] : pbuf_r; // R3

   // local_paper_advance deliberately unused here; R16

   // read values
   wire         msb_bit  = msb_follows_loopback_strap & ~msb_zero_strap & loopback_test_bit_r; // R11 R12
   ctb_char_t   kb_low;
   assign kb_low = loopback_test_bit_r ? `CTB_RST_CHAR : kbuf_r; // R19 R17
   wire [15:0]  kbs_val = (16'(done_r) << `CTB_BIT_FLAG) | (16'(kie_r) << `CTB_BIT_IE); // R10
   wire [15:0]  kbb_val = (16'(msb_bit) << `CTB_BIT_MSB) | 16'(kb_low);
   wire [15:0]  prs_val = (16'(ready_r) << `CTB_BIT_FLAG) | (16'(pie_r) << `CTB_BIT_IE) |
                          (16'(loopback_test_bit_r) << `CTB_BIT_LOOPBACK_TEST_BIT); // R10
   wire [15:0]  rd_val  = hit_kbs ? kbs_val :
                          hit_kbb ? kbb_val :
                          hit_prs ? prs_val : `CTB_RST_DATA;
   wire [15:0]  rdata_nxt = (bus_rd & hit_any) ? rd_val : rdata_r;

   // interrupts, keyboard first
   wire         kb_irq  = done_r & kie_r; // R9
   wire         pr_irq  = ready_r & pie_r; // R5
   ctb_src_t    src;
   assign src = kb_irq ? CTB_SRC_KB : CTB_SRC_PR; // R22
   wire [7:0]   vec_sel = (src == CTB_SRC_KB) ? `CTB_VEC_KB : `CTB_VEC_PR; // R6
   wire         vec_go  = irq_grant & (kb_irq | pr_irq);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         kbuf_r <= `CTB_RST_CHAR;
      end else begin
         kbuf_r <= kbuf_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         done_r <= `CTB_RST_BIT;
      end else begin
         done_r <= done_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         kie_r <= `CTB_RST_BIT;
      end else begin
         kie_r <= kie_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pie_r <= `CTB_RST_BIT;
      end else begin
         pie_r <= pie_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         loopback_test_bit_r <= `CTB_RST_BIT;
      end else begin
         loopback_test_bit_r <= mnt_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pend_r <= `CTB_RST_BIT;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ready_r <= `CTB_RST_BIT;
      end else begin
         ready_r <= ready_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pbuf_r <= `CTB_RST_CHAR;
      end else begin
         pbuf_r <= pbuf_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pstb_r <= `CTB_RST_BIT;
      end else begin
         pstb_r <= prb_wr; // R3 R14
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_r <= `CTB_RST_DATA;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ack_r <= `CTB_RST_BIT;
      end else begin
         ack_r <= (bus_rd | bus_wr) & hit_any; // R1
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         vec_r <= `CTB_RST_VEC;
      end else begin
         vec_r <= vec_go ? vec_sel : vec_r;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         vec_vld_r <= `CTB_RST_BIT;
      end else begin
         vec_vld_r <= vec_go; // R6
      end
   end

   assign bus_rdata        = rdata_r;
   assign bus_ack          = ack_r;
   assign irq_req          = kb_irq | pr_irq; // R5 R9
   assign irq_vector       = vec_r;
   assign irq_vector_valid = vec_vld_r;
   assign link.print_code  = pbuf_r; // R13
   assign link.print_strobe = pstb_r; // R13

endmodule

`default_nettype wire

// *** hw/ctb_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none

interface ctb_link_if;
   import ctb_pkg::*;
   ctb_char_t key_code;
   logic      key_strobe;
   ctb_char_t print_code;
   logic      print_strobe;
   logic      printer_ready;
   logic      local_paper_advance;

   modport ctl (
      input  key_code,
      input  key_strobe,
      output print_code,
      output print_strobe,
      input  printer_ready,
      input  local_paper_advance
   );

   modport term (
      output key_code,
      output key_strobe,
      input  print_code,
      input  print_strobe,
      output printer_ready,
      output local_paper_advance
   );
endinterface

`default_nettype wire

// *** hw/ctb_map.svh ***
`ifndef CTB_MAP_SVH
`define CTB_MAP_SVH

// default base address, octal 777560
`define CTB_BASE_ADDR   18'h3FF70
// byte offsets of the four registers from the base
`define CTB_OFS_KBS     3'h0
`define CTB_OFS_KBB     3'h2
`define CTB_OFS_PRS     3'h4
`define CTB_OFS_PRB     3'h6
// field positions
`define CTB_BIT_FLAG    4'h7
`define CTB_BIT_IE      4'h6
`define CTB_BIT_LOOPBACK_TEST_BIT   4'h2
`define CTB_BIT_MSB     4'h7
// interrupt vectors, octal 60 and 64
`define CTB_VEC_KB      8'h30
`define CTB_VEC_PR      8'h34
// reset values
`define CTB_RST_CHAR    7'h00
`define CTB_RST_BIT     1'h0
`define CTB_RST_DATA    16'h0000
`define CTB_RST_VEC     8'h00
// terminal timing and buffering
`define CTB_KEY_GAP_CYC 8'h04
`define CTB_FIFO_DEPTH  8
`define CTB_CHAR_W      7

`endif

// *** hw/ctb_pkg.sv ***
package ctb_pkg;

   typedef logic [6:0] ctb_char_t;

   typedef enum logic {
      CTB_SRC_KB,
      CTB_SRC_PR
   } ctb_src_t;

   typedef enum logic {
      CTB_KEY_IDLE,
      CTB_KEY_GAP
   } ctb_key_state_t;

endpackage

// *** hw/ctb_terminal.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ctb_map.svh"

module ctb_fifo #(
   parameter int WIDTH = `CTB_CHAR_W,
   parameter int DEPTH = `CTB_FIFO_DEPTH
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wptr_r;
   logic [AW:0]      rptr_r;

   wire              empty = (wptr_r == rptr_r);
   wire              full  = (wptr_r[AW-1:0] == rptr_r[AW-1:0]) && (wptr_r[AW] != rptr_r[AW]);
   wire              push  = in_valid & ~full;
   wire              pop   = out_ready & ~empty;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wptr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         wptr_r <= push ? wptr_r + (AW+1)'(1) : wptr_r;
         rptr_r <= pop ? rptr_r + (AW+1)'(1) : rptr_r;
      end
   end

   assign in_ready  = ~full;
   assign out_valid = ~empty;
   assign out_data  = mem[rptr_r[AW-1:0]];
endmodule

module ctb_terminal
   import ctb_pkg::*;
#(
   parameter int         FIFO_DEPTH  = `CTB_FIFO_DEPTH,
   parameter logic [7:0] KEY_GAP_CYC = `CTB_KEY_GAP_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [6:0] key_in_code,
   input  wire logic       key_in_valid,
   output logic            key_in_ready,
   output logic [6:0]      print_out_code,
   output logic            print_out_valid,
   input  wire logic       print_done,
   input  wire logic       paper_advance_in,
   ctb_link_if.term        link
);

   ctb_key_state_t st_r;
   logic [7:0]     gap_r;
   ctb_char_t      kcode_r;
   logic           kstb_r;
   ctb_char_t      pcode_r;
   logic           pvld_r;
   logic           prdy_r;
   logic           adv_r;
   ctb_char_t      f_data;
   logic           f_valid;

   // keystrokes are held while paper advances locally
   wire            take = (st_r == CTB_KEY_IDLE) & f_valid & ~adv_r; // R14 R16

   ctb_fifo #(
      .WIDTH (`CTB_CHAR_W),
      .DEPTH (FIFO_DEPTH)
   ) u_key_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_data   (key_in_code),
      .in_valid  (key_in_valid),
      .in_ready  (key_in_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (take)
   );

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r    <= CTB_KEY_IDLE;
         gap_r   <= 8'h00;
         kcode_r <= `CTB_RST_CHAR;
         kstb_r  <= `CTB_RST_BIT;
      end else begin
         kstb_r  <= take; // R13
         kcode_r <= take ? f_data : kcode_r;
         case (st_r)
            CTB_KEY_IDLE: begin
               if (take) begin
                  st_r  <= CTB_KEY_GAP;
                  gap_r <= KEY_GAP_CYC;
               end
            end
            CTB_KEY_GAP: begin
               gap_r <= gap_r - 8'h01;
               if (gap_r <= 8'h01) begin
                  st_r <= CTB_KEY_IDLE;
               end
            end
            default: st_r <= CTB_KEY_IDLE;
         endcase
      end
   end

   // printer: one character held until the user side finishes it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pcode_r <= `CTB_RST_CHAR;
         pvld_r  <= `CTB_RST_BIT;
         prdy_r  <= `CTB_RST_BIT;
         adv_r   <= `CTB_RST_BIT;
      end else begin
         adv_r   <= paper_advance_in;
         pcode_r <= link.print_strobe ? link.print_code : pcode_r; // R13
         pvld_r  <= link.print_strobe | (pvld_r & ~print_done); // R14
         prdy_r  <= ~link.print_strobe & ~(pvld_r & ~print_done) & ~paper_advance_in;
      end
   end

   assign print_out_code           = pcode_r;
   assign print_out_valid          = pvld_r;
   assign link.key_code            = kcode_r;
   assign link.key_strobe          = kstb_r;
   assign link.printer_ready       = prdy_r;
   assign link.local_paper_advance = adv_r;

endmodule

`default_nettype wire

// *** verif/console_terminal_bus_interface_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ctb_map.svh"
module console_terminal_bus_interface_tb;
   import ctb_pkg::*;
   localparam logic [17:0] KEYBOARD_STATUS_REG = `CTB_BASE_ADDR;
   localparam logic [17:0] KEYBOARD_DATA_REG = KEYBOARD_STATUS_REG + 18'h2;
   localparam logic [17:0] PRINTER_STATUS_REG = KEYBOARD_STATUS_REG + 18'h4;
   localparam logic [17:0] PRINTER_DATA_REG = KEYBOARD_STATUS_REG + 18'h6;
   localparam logic [7:0]  GAP = 8'h14;
   logic        ref_clk, rst, bus_rd, bus_wr, bus_ack, irq_req, irq_grant;
   logic        irq_vector_valid, msb_follows_loopback_strap, msb_zero_strap;
   logic        key_in_valid, key_in_ready, print_out_valid, print_done;
   logic        paper_advance_in, k;
   logic [17:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata, q;
   logic [7:0]  irq_vector;
   ctb_char_t   key_in_code, print_out_code;
   int          fail_count = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          n;
   ctb_link_if ctb_link_if_i ();
   ctb_controller ctb_controller_i (.ref_clk, .rst, .bus_addr, .bus_wdata, .bus_rd, .bus_wr,
      .bus_rdata, .bus_ack, .irq_req, .irq_grant, .irq_vector, .irq_vector_valid,
      .msb_follows_loopback_strap, .msb_zero_strap, .link(ctb_link_if_i.ctl));
   ctb_terminal #(.KEY_GAP_CYC(GAP)) ctb_terminal_i (.ref_clk, .rst, .key_in_code,
      .key_in_valid, .key_in_ready, .print_out_code, .print_out_valid, .print_done,
      .paper_advance_in, .link(ctb_link_if_i.term));
   ctb_link_sva #(.KEY_GAP_CYC(GAP)) ctb_link_sva_i (.ref_clk, .rst,
      .key_code(ctb_link_if_i.key_code), .key_strobe(ctb_link_if_i.key_strobe),
      .print_code(ctb_link_if_i.print_code), .print_strobe(ctb_link_if_i.print_strobe),
      .printer_ready(ctb_link_if_i.printer_ready),
      .local_paper_advance(ctb_link_if_i.local_paper_advance));
   always #5 ref_clk = ~ref_clk;
   task automatic final_report;
      if (fail_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic acc(input logic w, input logic [17:0] a, input logic [15:0] d);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = w;
      bus_rd = !w;
      @(negedge ref_clk);
      k = bus_ack;
      q = bus_rdata;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic rd(input logic [17:0] a, input logic [15:0] e, input string m);
      acc(1'b0, a, 16'h0000);
      chk(k === 1'b1 && q === e, m);
   endtask
   task automatic wr(input logic [17:0] a, input logic [15:0] d);
      acc(1'b1, a, d);
      chk(k === 1'b1, "write not acked");
   endtask
   task automatic grant(input logic [7:0] v);
      irq_grant = 1'b1;
      @(negedge ref_clk);
      chk(irq_vector_valid === 1'b1 && irq_vector === v, "vector");
      irq_grant = 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic printed;
      print_done = 1'b1;
      @(negedge ref_clk);
      print_done = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask
   task automatic push(input ctb_char_t c);
      key_in_code = c;
      key_in_valid = 1'b1;
      @(negedge ref_clk);
      key_in_valid = 1'b0;
   endtask
   task automatic wait_done;
      q = 16'h0000;
      for (int i = 0; i < 40 && q[7] !== 1'b1; i++) acc(1'b0, KEYBOARD_STATUS_REG, 16'h0000);
      chk(q[7] === 1'b1, "no keyboard done");
   endtask
   task automatic t_reset;
      rd(KEYBOARD_STATUS_REG, 16'h0000, "kbs reset");
      rd(PRINTER_STATUS_REG, 16'h0080, "prs reset");
      rd(PRINTER_DATA_REG, 16'h0000, "prb read");
      acc(1'b0, KEYBOARD_STATUS_REG + 18'h1, 16'h0000);
      chk(k === 1'b0, "odd address acked");
      acc(1'b0, KEYBOARD_STATUS_REG + 18'h8, 16'h0000);
      chk(k === 1'b0, "address above acked");
      acc(1'b1, KEYBOARD_STATUS_REG - 18'h2, 16'h0052);
      chk(k === 1'b0 && print_out_valid === 1'b0, "address below acked");
   endtask
   task automatic t_print;
      wr(PRINTER_STATUS_REG, 16'h0040);
      chk(irq_req === 1'b1, "printer irq");
      grant(8'h34);
      wr(PRINTER_DATA_REG, 16'h0041);
      chk(print_out_valid === 1'b1 && print_out_code === 7'h41, "print char");
      rd(PRINTER_STATUS_REG, 16'h0040, "ready not cleared");
      chk(irq_req === 1'b0, "irq while busy");
      printed();
      rd(PRINTER_STATUS_REG, 16'h00C0, "ready not back");
      wr(PRINTER_STATUS_REG, 16'h0000);
      chk(irq_req === 1'b0, "irq with enable off");
   endtask
   task automatic t_keys;
      ctb_char_t c;
      for (int i = 0; i < 3; i++) begin
         c = (i == 0) ? 7'h00 : (i == 1) ? 7'h41 : 7'h7F;
         push(c);
         wait_done();
         chk(irq_req === 1'b0, "keyboard irq with enable off");
         rd(KEYBOARD_DATA_REG, {9'h000, c}, "key char");
         rd(KEYBOARD_STATUS_REG, 16'h0000, "done not cleared");
      end
      wr(KEYBOARD_STATUS_REG, 16'h0040);
      chk(irq_req === 1'b0, "irq without done");
      push(7'h55);
      wait_done();
      chk(irq_req === 1'b1, "keyboard irq");
      rd(KEYBOARD_STATUS_REG, 16'h00C0, "kbs enable readback");
      wr(PRINTER_STATUS_REG, 16'h0040);
      grant(8'h30);
      rd(KEYBOARD_DATA_REG, 16'h0055, "key char");
      grant(8'h34);
      wr(PRINTER_DATA_REG, 16'h0055);
      chk(print_out_code === 7'h55, "echo not printed");
      printed();
      wr(KEYBOARD_STATUS_REG, 16'h0000);
      wr(PRINTER_STATUS_REG, 16'h0000);
   endtask
   task automatic t_loop;
      msb_follows_loopback_strap = 1'b1;
      wr(PRINTER_STATUS_REG, 16'h0004);
      wr(PRINTER_DATA_REG, 16'h0033);
      rd(KEYBOARD_STATUS_REG, 16'h0080, "loopback done");
      rd(KEYBOARD_DATA_REG, 16'h0080, "strap one bit 07");
      printed();
      msb_follows_loopback_strap = 1'b0;
      msb_zero_strap = 1'b1;
      wr(PRINTER_DATA_REG, 16'h0033);
      rd(KEYBOARD_DATA_REG, 16'h0000, "strap two bit 07");
      printed();
      wr(PRINTER_STATUS_REG, 16'h0000);
   endtask
   task automatic t_fifo;
      paper_advance_in = 1'b1;
      repeat (2) @(negedge ref_clk);
      n = 0;
      for (int i = 0; i < 10; i++) begin
         key_in_code = 7'h10 + 7'(i);
         key_in_valid = 1'b1;
         if (key_in_ready === 1'b1) n++;
         @(negedge ref_clk);
      end
      key_in_valid = 1'b0;
      chk(n == `CTB_FIFO_DEPTH, "fifo depth");
      rd(KEYBOARD_STATUS_REG, 16'h0000, "done during advance");
      paper_advance_in = 1'b0;
      for (int i = 0; i < 8; i++) begin
         wait_done();
         rd(KEYBOARD_DATA_REG, 16'h0010 + 16'(i), "fifo order");
      end
   endtask
   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      {bus_rd, bus_wr, irq_grant, key_in_valid, print_done, paper_advance_in} = '0;
      {msb_follows_loopback_strap, msb_zero_strap} = 2'b00;
      bus_addr = 18'h00000;
      bus_wdata = 16'h0000;
      key_in_code = 7'h00;
      repeat (8) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      t_reset();
      t_print();
      t_keys();
      t_loop();
      t_fifo();
      final_report();
   end
endmodule
`default_nettype wire

// *** verif/ctb_link_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module ctb_link_sva
   import ctb_pkg::*;
#(
   parameter logic [7:0] KEY_GAP_CYC = 8'h04
) (
   input wire logic      ref_clk,
   input wire logic      rst,
   input wire ctb_char_t key_code,
   input wire logic      key_strobe,
   input wire ctb_char_t print_code,
   input wire logic      print_strobe,
   input wire logic      printer_ready,
   input wire logic      local_paper_advance
);
   logic [7:0] since_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // cycles since last keystroke, saturating
   always_ff @(posedge ref_clk) begin
      if (rst) since_r <= 8'hFF;
      else if (key_strobe) since_r <= 8'h00;
      else if (since_r != 8'hFF) since_r <= since_r + 8'h01;
   end
   sequence s_adv_held; local_paper_advance [*2]; endsequence
   sequence s_busy_next; ##1 !printer_ready; endsequence
   property p_key_pulse; key_strobe |=> !key_strobe; endproperty
   property p_print_pulse; print_strobe |=> !print_strobe; endproperty
   property p_key_code; !$stable(key_code) |-> key_strobe; endproperty
   property p_print_code; !$stable(print_code) |-> print_strobe; endproperty
   property p_key_gap; key_strobe |-> since_r >= KEY_GAP_CYC; endproperty
   property p_print_busy; print_strobe |-> s_busy_next; endproperty
   property p_adv_no_key; s_adv_held |-> !key_strobe; endproperty
   property p_adv_busy; s_adv_held |-> !printer_ready; endproperty
   a_key_pulse: assert property (p_key_pulse)
      else $error("keystroke strobe too long");
   a_print_pulse: assert property (p_print_pulse)
      else $error("print strobe too long");
   a_key_code: assert property (p_key_code)
      else $error("key code moved without strobe");
   a_print_code: assert property (p_print_code)
      else $error("print code moved without strobe");
   a_key_gap: assert property (p_key_gap)
      else $error("keystrokes too close");
   a_print_busy: assert property (p_print_busy)
      else $error("printer still ready after strobe");
   a_adv_no_key: assert property (p_adv_no_key)
      else $error("keystroke during paper advance");
   a_adv_busy: assert property (p_adv_busy)
      else $error("printer ready during paper advance");
endmodule
`default_nettype wire
